// *** bench/frg_cpu_model.sv ***
// CPU core model issuing store and load program requests
`timescale 1ns/1ps
`include "frg_consts.svh"
module frg_cpu_model
    import frg_pkg::*;
(
    // Clock and guard status
    input wire logic i_clock,
    input wire logic i_halt,
    input wire logic i_busy,
    // Store program request
    output logic o_stp_req,
    output frg_op_e o_stp_op,
    output logic [`FRG_AW-1:0] o_stp_addr,
    output logic [`FRG_AW-1:0] o_stp_pc,
    output logic [5:0] o_stp_data,
    // Load program request and execute address
    output logic o_lpm_req,
    output logic [`FRG_AW-1:0] o_lpm_addr,
    output logic [`FRG_AW-1:0] o_lpm_pc,
    output logic [`FRG_AW-1:0] o_exec_pc
);
    //==========================================================
    // Idle values at time zero
    initial begin
        o_stp_req = 1'b0;
        o_stp_op = FRG_OP_FILL;
        o_stp_addr = 15'h0000;
        o_stp_pc = 15'h0000;
        o_stp_data = 6'h3F;
        o_lpm_req = 1'b0;
        o_lpm_addr = 15'h0000;
        o_lpm_pc = 15'h0000;
        o_exec_pc = 15'h7E10;
    end
    //==========================================================
    // A halted core issues nothing until it is released
    task automatic wait_run();
        while (i_halt === 1'b1) begin
            @(posedge i_clock);
        end
    endtask : wait_run

    // One-cycle store program request
    task automatic stp(input frg_op_e op, input logic [14:0] a, pc,
                       input logic [5:0] d);
        wait_run();
        o_stp_req <= 1'b1;
        o_stp_op <= op;
        o_stp_addr <= a;
        o_stp_pc <= pc;
        o_stp_data <= d;
        @(posedge i_clock);
        // Released address and data lines carry no stale value
        o_stp_req <= 1'b0;
        o_stp_addr <= ~a;
        o_stp_data <= ~d;
        @(posedge i_clock);
    endtask : stp

    // One-cycle load program request; rude ignores the busy flag
    task automatic lpm(input logic [14:0] a, pc, input logic rude);
        if (!rude && i_busy === 1'b1 && a < `FRG_NRWR_START) begin
            @(posedge i_clock);
        end else begin
            wait_run();
            o_lpm_req <= 1'b1;
            o_lpm_addr <= a;
            o_lpm_pc <= pc;
            @(posedge i_clock);
            o_lpm_req <= 1'b0;
            o_lpm_addr <= ~a;
            @(posedge i_clock);
        end
    endtask : lpm

    // Move execution to another address
    task automatic set_pc(input logic [14:0] pc);
        o_exec_pc <= pc;
        @(posedge i_clock);
    endtask : set_pc
endmodule : frg_cpu_model

// *** bench/frg_guard_test.sv ***
// Self-checking testbench for the flash guard
`timescale 1ns/1ps
`include "frg_consts.svh"
module frg_guard_test;
    import frg_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, fdone, lk_we, cerase, vec;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, start, halt, busy, grant, deny, irq_blk, irq, rerr;
    logic [1:0] bsz, ans, c;
    logic [5:0] lk_data, sdat;
    logic [14:0] saddr, spc, laddr, lpc, xpc, faddr, f_addr;
    logic sreq, lreq;
    frg_op_e sop, fop, f_op;
    int n_mismatch, total_checks, n_start;
    logic [1:0] codes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [14:0] starts [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};

    frg_guard frg_guard_inst (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_STP_REQ(sreq), .I_STP_OP(sop),
        .I_STP_ADDR(saddr), .I_STP_PC(spc), .I_STP_DATA(sdat),
        .I_LPM_REQ(lreq), .I_LPM_ADDR(laddr), .I_LPM_PC(lpc),
        .I_EXEC_PC(xpc), .I_BOOT_SIZE_SELECT(bsz),
        .I_PGM_LOCK_WE(lk_we), .I_PGM_LOCK_DATA(lk_data),
        .I_CHIP_ERASE(cerase), .I_FLASH_DONE(fdone),
        .O_FLASH_START(start), .O_FLASH_OP(fop), .O_FLASH_ADDR(faddr),
        .O_CPU_HALT(halt), .O_RWR_BLOCK(busy), .O_LPM_GRANT(grant),
        .O_LPM_DENY(deny), .O_IRQ_BLOCK(irq_blk), .O_IRQ(irq)
    );
    frg_cpu_model frg_cpu_model_inst (
        .i_clock(clk), .i_halt(halt), .i_busy(busy), .o_stp_req(sreq),
        .o_stp_op(sop), .o_stp_addr(saddr), .o_stp_pc(spc),
        .o_stp_data(sdat), .o_lpm_req(lreq), .o_lpm_addr(laddr),
        .o_lpm_pc(lpc), .o_exec_pc(xpc)
    );
    //==========================================================
    // Clock and watchdog; a full run takes a few hundred cycles
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    // Records flash starts and load program answers
    always @(posedge clk) begin
        if (start === 1'b1) begin
            n_start++;
            f_op = fop;
            f_addr = faddr;
        end
        if (grant === 1'b1 || deny === 1'b1) ans = {grant, deny};
    end
    //==========================================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // APB transfer; bounded wait for the ready answer
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        chk("pready", pready, 32'h1);
        rdata = prdata;
        // Error response stands only in the ready cycle
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input string n, input logic [11:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rdata, e);
    endtask : rd

    task automatic stp_chk(input frg_op_e op, input logic [14:0] a, pc,
                           input logic st, hl);
        int s0;
        s0 = n_start;
        frg_cpu_model_inst.stp(op, a, pc, 6'h3F);
        @(posedge clk);
        chk("start", n_start - s0, {31'h0, st});
        chk("halt", halt, {31'h0, hl});
        if (st) chk("addr", f_addr, {17'h0, a});
        if (st) chk("op", f_op, {30'h0, op});
    endtask : stp_chk

    task automatic lpm_chk(input logic [14:0] a, pc, input logic rude,
                           input logic [1:0] e);
        ans = 2'b00;
        frg_cpu_model_inst.lpm(a, pc, rude);
        @(posedge clk);
        chk("lpm", ans, {30'h0, e});
    endtask : lpm_chk

    // Flash array ends the operation, then software clears busy
    task automatic finish();
        repeat (3) @(posedge clk);
        fdone <= 1'b1;
        @(posedge clk);
        fdone <= 1'b0;
        repeat (2) @(posedge clk);
        chk("halt", halt, 32'h0);
        chk("busy", busy, 32'h1);
        apb(1'b1, `FRG_OFF_CTRL, {30'h0, vec, 1'b1});
        chk("busy", busy, 32'h0);
    endtask : finish

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    //==========================================================
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, fdone, lk_we, cerase, vec} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        bsz = 2'h3;
        lk_data = 6'h3F;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd("lock", `FRG_OFF_LOCK, 32'h3F);
        rd("stat", `FRG_OFF_STAT, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", rerr, 32'h1);
        rd("iclr", `FRG_OFF_ICLR, 32'h0);
        apb(1'b1, `FRG_OFF_IEN, 32'h1);
        rd("ien", `FRG_OFF_IEN, 32'h1);
        $display("test registers done");
        stp_chk(FRG_OP_ERASE, 15'h0100, 15'h7E10, 1, 0);
        chk("busy", busy, 32'h1);
        rd("stat", `FRG_OFF_STAT, 32'h5);
        lpm_chk(15'h7100, 15'h7E10, 1'b0, 2'b10);
        lpm_chk(15'h0200, 15'h7E10, 1'b1, 2'b01);
        finish();
        rd("istat", `FRG_OFF_ISTAT, 32'h5);
        chk("irq", irq, 32'h1);
        apb(1'b1, `FRG_OFF_ICLR, 32'h7);
        @(posedge clk);
        chk("irq", irq, 32'h0);
        $display("test read-while-write done");
        // Buffer fill from boot code is issued but sets no busy flag
        stp_chk(FRG_OP_FILL, 15'h0100, 15'h7E10, 1, 0);
        chk("busy", busy, 32'h0);
        stp_chk(FRG_OP_ERASE, 15'h0100, 15'h0200, 0, 0);
        rd("istat", `FRG_OFF_ISTAT, 32'h2);
        chk("irq", irq, 32'h0);
        apb(1'b1, `FRG_OFF_ICLR, 32'h7);
        $display("test app spm done");
        // Application pair modes through software lock writes
        vec = 1'b1;
        for (int k = 0; k < 4; k++) begin
            c = codes[k];
            cerase <= 1'b1;
            @(posedge clk);
            cerase <= 1'b0;
            @(posedge clk);
            rd("lock", `FRG_OFF_LOCK, 32'h3F);
            frg_cpu_model_inst.stp(FRG_OP_LOCK, 15'h0, 15'h7E10, {4'h3, c});
            @(posedge clk);
            rd("lock", `FRG_OFF_LOCK, {28'h3, c});
            stp_chk(FRG_OP_WRITE, 15'h100, 15'h7E10, c[0], 0);
            if (c[0]) finish();
            lpm_chk(15'h0100, 15'h7E10, 1'b0, {c[1], ~c[1]});
            apb(1'b1, `FRG_OFF_CTRL, 32'h2);
            frg_cpu_model_inst.set_pc(15'h0100);
            @(posedge clk);
            chk("irqblk", irq_blk, {31'h0, ~c[1]});
            frg_cpu_model_inst.set_pc(15'h7E10);
        end
        $display("test app lock done");
        // Boot pair modes through programming mode lock writes
        vec = 1'b0;
        apb(1'b1, `FRG_OFF_CTRL, 32'h0);
        for (int k = 0; k < 4; k++) begin
            c = codes[k];
            cerase <= 1'b1;
            @(posedge clk);
            cerase <= 1'b0;
            lk_we <= 1'b1;
            lk_data <= {2'b11, c, 2'b11};
            @(posedge clk);
            lk_we <= 1'b0;
            @(posedge clk);
            rd("lock", `FRG_OFF_LOCK, {28'h3, c, 2'b11});
            stp_chk(FRG_OP_WRITE, 15'h7E80, 15'h7E10, c[0], c[0]);
            if (c[0]) finish();
            lpm_chk(15'h7E80, 15'h0100, 1'b0, {c[1], ~c[1]});
            chk("irqblk", irq_blk, {31'h0, ~c[1]});
        end
        $display("test boot lock done");
        for (int s = 0; s < 4; s++) begin
            bsz <= s[1:0];
            @(posedge clk);
            stp_chk(FRG_OP_ERASE, starts[s], 15'h7E10, 1, 1);
            finish();
        end
        $display("test boot size done");
        report_and_stop();
    end
endmodule : frg_guard_test

// *** verilog/frg_consts.svh ***
// Constants for the flash read-while-write and boot lock guard
//=============================================================
`ifndef FRG_CONSTS_SVH
`define FRG_CONSTS_SVH
//=============================================================
// Flash map, word addresses
`define FRG_AW 15
`define FRG_NRWR_START 15'h7000
`define FRG_BOOT_START_00 15'h7000
`define FRG_BOOT_START_01 15'h7800
`define FRG_BOOT_START_10 15'h7C00
`define FRG_BOOT_START_11 15'h7E00
//=============================================================
// Register offsets
`define FRG_OFF_CTRL 12'h000
`define FRG_OFF_STAT 12'h004
`define FRG_OFF_LOCK 12'h008
`define FRG_OFF_ISTAT 12'h00C
`define FRG_OFF_ICLR 12'h010
`define FRG_OFF_IEN 12'h014
//=============================================================
// Field positions and reset values
`define FRG_LK_APP_LO 0
`define FRG_LK_APP_HI 1
`define FRG_LK_BOOT_LO 2
`define FRG_LK_BOOT_HI 3
`define FRG_LK_RST 6'h3F
`define FRG_CTRL_CLR 0
`define FRG_CTRL_VEC 1
`define FRG_EV_DONE 0
`define FRG_EV_STP_REF 1
`define FRG_EV_LPM_REF 2
`endif

// *** verilog/frg_guard.sv ***
// Flash read-while-write and boot lock access guard
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "frg_consts.svh"
module frg_guard
    import frg_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Store program requests from the CPU
    input wire logic I_STP_REQ,
    input wire frg_op_e I_STP_OP,
    input wire logic [`FRG_AW-1:0] I_STP_ADDR,
    input wire logic [`FRG_AW-1:0] I_STP_PC,
    input wire logic [5:0] I_STP_DATA,
    // Load program requests from the CPU
    input wire logic I_LPM_REQ,
    input wire logic [`FRG_AW-1:0] I_LPM_ADDR,
    input wire logic [`FRG_AW-1:0] I_LPM_PC,
    // Execution context
    input wire logic [`FRG_AW-1:0] I_EXEC_PC,
    input wire logic [1:0] I_BOOT_SIZE_SELECT,
    // Programming-mode lock access
    input wire logic I_PGM_LOCK_WE,
    input wire logic [5:0] I_PGM_LOCK_DATA,
    input wire logic I_CHIP_ERASE,
    // Flash array side
    input wire logic I_FLASH_DONE,
    output logic O_FLASH_START,
    output frg_op_e O_FLASH_OP,
    output logic [`FRG_AW-1:0] O_FLASH_ADDR,
    // Guard outputs
    output logic O_CPU_HALT,
    output logic O_RWR_BLOCK,
    output logic O_LPM_GRANT,
    output logic O_LPM_DENY,
    output logic O_IRQ_BLOCK,
    output logic O_IRQ
);

    //=========================================================
    // Region decode

    // Boot start is clamped so it never falls below the fixed limit
    function automatic logic [`FRG_AW-1:0] boot_start(
        input logic [1:0] sz
    );
        logic [`FRG_AW-1:0] s;
        s = `FRG_BOOT_START_11;
        unique case (sz)
            2'h0: s = `FRG_BOOT_START_00;
            2'h1: s = `FRG_BOOT_START_01;
            2'h2: s = `FRG_BOOT_START_10;
            2'h3: s = `FRG_BOOT_START_11;
        endcase
        if (s < `FRG_NRWR_START) begin
            s = `FRG_NRWR_START;
        end
        return s;
    endfunction : boot_start

    function automatic logic in_boot(
        input logic [`FRG_AW-1:0] a,
        input logic [1:0] sz
    );
        return a >= boot_start(sz);
    endfunction : in_boot

    function automatic logic in_rwr(input logic [`FRG_AW-1:0] a);
        return a < `FRG_NRWR_START;
    endfunction : in_rwr

    //=========================================================
    // State
    frg_state_e state_r;
    logic busy_r;
    logic vec_boot_r;
    logic [5:0] lock_r;
    logic [2:0] istat_r;
    logic [2:0] ien_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic start_r;
    frg_op_e op_r;
    logic [`FRG_AW-1:0] faddr_r;
    logic halt_r;
    logic lgrant_r;
    logic ldeny_r;
    logic irqblk_r;
    logic irq_r;

    //=========================================================
    // Store program decision
    logic stp_boot;
    logic stp_prog;
    logic tgt_boot;
    logic wr_locked;
    logic stp_go;
    logic stp_ref;
    logic flash_go;
    // Only boot-resident code may start programming
    assign stp_boot = in_boot(I_STP_PC, I_BOOT_SIZE_SELECT);
    assign stp_prog = (I_STP_OP == FRG_OP_ERASE) ||
                      (I_STP_OP == FRG_OP_WRITE);
    assign tgt_boot = in_boot(I_STP_ADDR, I_BOOT_SIZE_SELECT);
    // Low bit programmed forbids writes; general lock unused
    assign wr_locked = tgt_boot ? !lock_r[`FRG_LK_BOOT_LO]
                     : !lock_r[`FRG_LK_APP_LO];
    assign stp_go = I_STP_REQ && stp_boot &&
                    (state_r == FRG_IDLE) &&
                    !(stp_prog && wr_locked);
    assign stp_ref = I_STP_REQ && !stp_go;
    assign flash_go = stp_go && (I_STP_OP != FRG_OP_LOCK);

    //=========================================================
    // Load program decision
    logic lpm_src_boot;
    logic lpm_tgt_boot;
    logic lpm_bad;
    assign lpm_src_boot = in_boot(I_LPM_PC, I_BOOT_SIZE_SELECT);
    assign lpm_tgt_boot = in_boot(I_LPM_ADDR, I_BOOT_SIZE_SELECT);
    // High bit programmed forbids cross-section reads
    assign lpm_bad =
        (busy_r && in_rwr(I_LPM_ADDR)) ||
        (lpm_src_boot && !lpm_tgt_boot &&
         !lock_r[`FRG_LK_APP_HI]) ||
        (!lpm_src_boot && lpm_tgt_boot &&
         !lock_r[`FRG_LK_BOOT_HI]);

    //=========================================================
    // APB decode
    logic apb_acc;
    logic apb_wr;
    logic clr_req;
    assign apb_acc = I_PSEL && I_PENABLE && pready_r;
    assign apb_wr = apb_acc && I_PWRITE;
    assign clr_req = apb_wr && (I_PADDR == `FRG_OFF_CTRL) &&
                     I_PWDATA[`FRG_CTRL_CLR];

    //=========================================================
    // Sequencer: halt choice uses the page address, not fetch
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            state_r <= FRG_IDLE;
        end else begin
            unique case (state_r)
                FRG_IDLE: begin
                    if (flash_go && stp_prog) begin
                        if (in_rwr(I_STP_ADDR)) begin
                            state_r <= FRG_BUSY_RWR;
                        end else begin
                            state_r <= FRG_BUSY_NRWR;
                        end
                    end
                end
                FRG_BUSY_RWR, FRG_BUSY_NRWR: begin
                    if (I_FLASH_DONE) begin
                        state_r <= FRG_IDLE;
                    end
                end
                default: state_r <= FRG_IDLE;
            endcase
        end
    end

    // CPU halt follows the no-read-while-write busy state
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            halt_r <= 1'b0;
        end else if (flash_go && stp_prog) begin
            halt_r <= !in_rwr(I_STP_ADDR);
        end else if (I_FLASH_DONE) begin
            halt_r <= 1'b0;
        end
    end

    // Busy flag: set on start wins over a software clear.
    // Clearing is taken only when idle; software is trusted
    // not to touch read-while-write code before then.
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            busy_r <= 1'b0;
        end else if (flash_go && stp_prog) begin
            busy_r <= 1'b1;
        end else if (clr_req && state_r == FRG_IDLE) begin
            busy_r <= 1'b0;
        end
    end

    // Flash command issue
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            start_r <= 1'b0;
            op_r <= FRG_OP_FILL;
            faddr_r <= '0;
        end else begin
            start_r <= flash_go;
            if (flash_go) begin
                op_r <= I_STP_OP;
                faddr_r <= I_STP_ADDR;
            end
        end
    end

    //=========================================================
    // Lock bits: only programmed (cleared) by AND, erased whole
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            lock_r <= `FRG_LK_RST;
        end else if (I_CHIP_ERASE) begin
            lock_r <= `FRG_LK_RST;
        end else begin
            lock_r <= lock_r &
                (I_PGM_LOCK_WE ? I_PGM_LOCK_DATA : 6'h3F) &
                ((stp_go && I_STP_OP == FRG_OP_LOCK) ?
                 I_STP_DATA : 6'h3F);
        end
    end

    //=========================================================
    // Load program answer, one cycle after the request
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            lgrant_r <= 1'b0;
            ldeny_r <= 1'b0;
        end else begin
            lgrant_r <= I_LPM_REQ && !lpm_bad;
            ldeny_r <= I_LPM_REQ && lpm_bad;
        end
    end

    // Interrupt masking for the protected cross section
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irqblk_r <= 1'b0;
        end else begin
            irqblk_r <=
                (!lock_r[`FRG_LK_APP_HI] && vec_boot_r &&
                 !in_boot(I_EXEC_PC, I_BOOT_SIZE_SELECT)) ||
                (!lock_r[`FRG_LK_BOOT_HI] && !vec_boot_r &&
                 in_boot(I_EXEC_PC, I_BOOT_SIZE_SELECT));
        end
    end

    //=========================================================
    // Control and interrupt enable registers
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            vec_boot_r <= 1'b0;
            ien_r <= 3'h0;
        end else if (apb_wr) begin
            if (I_PADDR == `FRG_OFF_CTRL) begin
                vec_boot_r <= I_PWDATA[`FRG_CTRL_VEC];
            end
            if (I_PADDR == `FRG_OFF_IEN) begin
                ien_r <= I_PWDATA[2:0];
            end
        end
    end

    // Sticky events; a new event beats the clear write
    logic [2:0] ev;
    logic [2:0] iclr;
    assign ev = {I_LPM_REQ && lpm_bad, stp_ref,
                 I_FLASH_DONE && state_r != FRG_IDLE};
    assign iclr = (apb_wr && I_PADDR == `FRG_OFF_ICLR) ?
                  I_PWDATA[2:0] : 3'h0;
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            istat_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~iclr) | ev;
            irq_r <= |(((istat_r & ~iclr) | ev) & ien_r);
        end
    end

    //=========================================================
    // APB slave: one wait state, read data latched early
    logic [31:0] rd_mux;
    logic rd_bad;
    always_comb begin
        rd_mux = 32'h0;
        rd_bad = 1'b0;
        unique case (I_PADDR)
            `FRG_OFF_CTRL: rd_mux = {30'h0, vec_boot_r, 1'b0};
            `FRG_OFF_STAT: rd_mux = {28'h0, start_r,
                                     state_r != FRG_IDLE,
                                     halt_r, busy_r};
            `FRG_OFF_LOCK: rd_mux = {26'h0, lock_r};
            `FRG_OFF_ISTAT: rd_mux = {29'h0, istat_r};
            `FRG_OFF_ICLR: rd_mux = 32'h0;
            `FRG_OFF_IEN: rd_mux = {29'h0, ien_r};
            default: rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= I_PSEL && I_PENABLE && !pready_r;
            if (I_PSEL && I_PENABLE && !pready_r) begin
                prdata_r <= I_PWRITE ? 32'h0 : rd_mux;
                pslverr_r <= rd_bad;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    //=========================================================
    // Outputs
    assign O_PRDATA = prdata_r;
    assign O_PREADY = pready_r;
    assign O_PSLVERR = pslverr_r;
    assign O_FLASH_START = start_r;
    assign O_FLASH_OP = op_r;
    assign O_FLASH_ADDR = faddr_r;
    assign O_CPU_HALT = halt_r;
    assign O_RWR_BLOCK = busy_r;
    assign O_LPM_GRANT = lgrant_r;
    assign O_LPM_DENY = ldeny_r;
    assign O_IRQ_BLOCK = irqblk_r;
    assign O_IRQ = irq_r;

    //=========================================================
    // Assertions
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    sequence s_prog_start;
        flash_go && stp_prog;
    endsequence

    sequence s_nrwr_start;
        s_prog_start ##0 !in_rwr(I_STP_ADDR);
    endsequence

    a_halt_nrwr: assert property (
        s_nrwr_start |=> O_CPU_HALT && O_FLASH_START)
        else $error("Fixed section programming did not halt CPU");
    a_run_rwr: assert property (
        s_prog_start ##0 in_rwr(I_STP_ADDR) |=> !O_CPU_HALT)
        else $error("Read-while-write programming halted CPU");
    a_busy_set: assert property (
        s_prog_start |=> O_RWR_BLOCK)
        else $error("Busy flag not set on programming");
    a_busy_hold: assert property (
        O_RWR_BLOCK && !clr_req |=> O_RWR_BLOCK)
        else $error("Busy flag dropped without clear");
    a_app_stp_ign: assert property (
        I_STP_REQ && !stp_boot |=> !O_FLASH_START)
        else $error("Store program from application taken");
    a_app_wr_lock: assert property (
        I_STP_REQ && stp_prog && !tgt_boot &&
        !lock_r[`FRG_LK_APP_LO] |=> !O_FLASH_START)
        else $error("Locked application write issued");
    a_boot_wr_lock: assert property (
        I_STP_REQ && stp_prog && tgt_boot &&
        !lock_r[`FRG_LK_BOOT_LO] |=> !O_FLASH_START)
        else $error("Locked boot write issued");
    a_halt_release: assert property (
        O_CPU_HALT && I_FLASH_DONE |=> !O_CPU_HALT [*2])
        else $error("CPU not released after operation");
    a_lock_erase: assert property (
        I_CHIP_ERASE |=> lock_r == `FRG_LK_RST)
        else $error("Chip erase did not clear locks");
    a_irq_app: assert property (
        !lock_r[`FRG_LK_APP_HI] && vec_boot_r &&
        !in_boot(I_EXEC_PC, I_BOOT_SIZE_SELECT) &&
        !I_CHIP_ERASE |=> O_IRQ_BLOCK)
        else $error("Interrupts not masked in application");
    a_rwr_read: assert property (
        I_LPM_REQ && O_RWR_BLOCK && in_rwr(I_LPM_ADDR)
        |=> O_LPM_DENY && !O_LPM_GRANT)
        else $error("Blocked region read allowed while busy");

endmodule : frg_guard

// *** verilog/frg_pkg.sv ***
// Types shared by the flash guard
package frg_pkg;
    // Store program operation codes
    typedef enum logic [1:0] {
        FRG_OP_FILL,
        FRG_OP_ERASE,
        FRG_OP_WRITE,
        FRG_OP_LOCK
    } frg_op_e;
    // Programming sequencer states
    typedef enum logic [1:0] {
        FRG_IDLE,
        FRG_BUSY_RWR,
        FRG_BUSY_NRWR
    } frg_state_e;
endpackage : frg_pkg
